// ### core/fps_store.sv
// Purpose: program flash store with code reads and redirected data writes
// Assumes: core holds move writes off while cpuStall is high; code reads then go unanswered
// Notes:   flash contents have no reset; they are non-volatile
`timescale 1ns/1ps
module fps_store #(
  parameter bit LARGE_VARIANT = 1'b1,
  parameter int SECTOR_BYTES  = fps_pkg::SECTOR_BYTES,
  parameter int WRITE_CYC     = fps_pkg::WRITE_CYCLES,
  parameter int ERASE_CYC     = fps_pkg::ERASE_CYCLES
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 nrst,
  // control levels
  input  wire fps_pkg::fps_ctl_type ctl,
  // code read port
  input  wire logic                 codeReadReq,
  input  wire logic                 codeReadIsFetch,
  input  wire logic [15:0]          codeReadAddr,
  output logic                      codeReadValid_reg,
  output logic [7:0]                codeReadData_reg,
  // external move write port
  input  wire logic                 moveWriteReq,
  input  wire fps_pkg::fps_req_type moveWrite,
  // external data RAM write out
  output logic                      xramWrite_reg,
  output fps_pkg::fps_req_type      xramWr_reg,
  // status
  output logic                      cpuStall_reg,
  output logic                      accessRefused_reg
);

  localparam int MAIN_BYTES = LARGE_VARIANT ? fps_pkg::LARGE_BYTES
                                            : fps_pkg::SMALL_BYTES;
  localparam int MAIN_AW    = $clog2(MAIN_BYTES);
  localparam int SEC_AW     = $clog2(SECTOR_BYTES);
  localparam int SCR_AW     = $clog2(fps_pkg::SCRATCH_BYTES);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic inScratch(input logic [15:0] a,
                                     input logic        sel);
    return sel && (a <= fps_pkg::SCRATCH_LAST);
  endfunction : inScratch

  function automatic logic inBacked(input logic [15:0] a);
    return LARGE_VARIANT ? 1'b1 : (a < fps_pkg::SMALL_LIMIT);
  endfunction : inBacked

  function automatic logic inWritable(input logic [15:0] a);
    return LARGE_VARIANT ? (a < fps_pkg::RESERVED_BASE)
                         : (a < fps_pkg::SMALL_LIMIT);
  endfunction : inWritable

  // ----------------------------------------------------------------
  // storage and state
  // ----------------------------------------------------------------
  logic [7:0]            mainMem_reg [MAIN_BYTES];
  logic [7:0]            scratchMem_reg [fps_pkg::SCRATCH_BYTES];
  fps_pkg::fps_state_type state_reg;
  logic [15:0]           opAddr_reg;
  logic [7:0]            opData_reg;
  logic                  opScratch_reg;
  logic                  opErase_reg;
  logic                  idle;
  logic                  wrScratch;
  logic                  writeOk;
  logic                  startOp;
  logic                  opDone;
  logic [7:0]            readByte;

  assign idle      = (state_reg == fps_pkg::ST_IDLE);
  assign wrScratch = inScratch(moveWrite.addr, ctl.scratchpadSel);
  assign writeOk   = wrScratch || inWritable(moveWrite.addr);
  // flash is only targeted while redirect is on
  assign startOp   = idle && moveWriteReq && ctl.writeRedirectEn
                     && writeOk;

  fps_op_timer #(
    .WRITE_CYC (WRITE_CYC),
    .ERASE_CYC (ERASE_CYC)
  ) u_timer (
    .clk     (clk),
    .nrst    (nrst),
    .start   (startOp),
    .isErase (ctl.eraseSel),
    .busy    (),
    .done    (opDone)
  );

  // ----------------------------------------------------------------
  // operation sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_reg <= fps_pkg::ST_IDLE;
    end else begin
      case (state_reg)
        fps_pkg::ST_IDLE: begin
          if (startOp) begin
            state_reg <= ctl.eraseSel ? fps_pkg::ST_ERASE
                                      : fps_pkg::ST_WRITE;
          end
        end
        fps_pkg::ST_WRITE,
        fps_pkg::ST_ERASE: begin
          if (opDone) begin
            state_reg <= fps_pkg::ST_IDLE;
          end
        end
        default: begin
          state_reg <= fps_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      opAddr_reg    <= 16'h0000;
      opData_reg    <= 8'h00;
      opScratch_reg <= 1'b0;
      opErase_reg   <= 1'b0;
    end else if (startOp) begin
      opAddr_reg    <= moveWrite.addr;
      opData_reg    <= moveWrite.data;
      opScratch_reg <= wrScratch;
      opErase_reg   <= ctl.eraseSel;
    end
  end

  // stall rises with the accepted request and falls with the timer
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cpuStall_reg <= 1'b0;
    end else if (startOp) begin
      cpuStall_reg <= 1'b1;
    end else if (opDone) begin
      cpuStall_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      accessRefused_reg <= 1'b0;
    end else begin
      accessRefused_reg <= idle && moveWriteReq && ctl.writeRedirectEn
                           && !writeOk;
    end
  end

  // ----------------------------------------------------------------
  // flash arrays
  // ----------------------------------------------------------------
  // a write can only clear bits; only an erase sets them again
  always_ff @(posedge clk) begin
    if (opDone && !opScratch_reg) begin
      if (opErase_reg) begin
        for (int i = 0; i < SECTOR_BYTES; i++) begin
          mainMem_reg[{opAddr_reg[MAIN_AW-1:SEC_AW], SEC_AW'(i)}] <=
            fps_pkg::ERASED_BYTE;
        end
      end else begin
        mainMem_reg[opAddr_reg[MAIN_AW-1:0]] <=
          mainMem_reg[opAddr_reg[MAIN_AW-1:0]] & opData_reg;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (opDone && opScratch_reg) begin
      if (opErase_reg) begin
        for (int i = 0; i < fps_pkg::SCRATCH_BYTES; i++) begin
          scratchMem_reg[i] <= fps_pkg::ERASED_BYTE;
        end
      end else begin
        scratchMem_reg[opAddr_reg[SCR_AW-1:0]] <=
          scratchMem_reg[opAddr_reg[SCR_AW-1:0]] & opData_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // code reads
  // ----------------------------------------------------------------
  // fetches never see the scratchpad, since it holds no code; they read main flash, or the erased byte where it is unbacked
  always_comb begin
    if (!codeReadIsFetch && inScratch(codeReadAddr, ctl.scratchpadSel)) begin
      readByte = scratchMem_reg[codeReadAddr[SCR_AW-1:0]];
    end else if (inBacked(codeReadAddr)) begin
      readByte = mainMem_reg[codeReadAddr[MAIN_AW-1:0]];
    end else begin
      readByte = fps_pkg::ERASED_BYTE;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      codeReadValid_reg <= 1'b0;
      codeReadData_reg  <= 8'h00;
    end else begin
      codeReadValid_reg <= idle && codeReadReq;
      if (idle && codeReadReq) begin
        codeReadData_reg <= readByte;
      end
    end
  end

  // ----------------------------------------------------------------
  // data RAM path
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      xramWrite_reg <= 1'b0;
      xramWr_reg    <= '0;
    end else begin
      xramWrite_reg <= idle && moveWriteReq
                       && !ctl.writeRedirectEn;
      if (idle && moveWriteReq && !ctl.writeRedirectEn) begin
        xramWr_reg <= moveWrite;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // one bit wider than the timer so a full erase length still fits
  localparam int  TWC = 21;
  logic [TWC-1:0] stallLen_reg;
  logic [7:0]     curByte;

  assign curByte = mainMem_reg[opAddr_reg[MAIN_AW-1:0]];

  always_ff @(posedge clk) begin
    if (!nrst || !cpuStall_reg) begin
      stallLen_reg <= '0;
    end else begin
      stallLen_reg <= stallLen_reg + 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_stall_while_busy: assert property (
    !idle |-> cpuStall_reg)
    else $error("core not stalled during flash operation");

  a_op_duration: assert property (
    $fell(cpuStall_reg) |-> stallLen_reg ==
      (opErase_reg ? TWC'(ERASE_CYC) : TWC'(WRITE_CYC)))
    else $error("flash operation length wrong");

  a_redirect_off: assert property (
    idle && moveWriteReq && !ctl.writeRedirectEn
      |=> xramWrite_reg && !cpuStall_reg
          && xramWr_reg == $past(moveWrite))
    else $error("data write not passed to data RAM");

  a_redirect_on: assert property (
    idle && moveWriteReq && ctl.writeRedirectEn
      |=> !xramWrite_reg && (cpuStall_reg != accessRefused_reg))
    else $error("redirected write leaked or was lost");

  a_reserved_refused: assert property (
    idle && moveWriteReq && ctl.writeRedirectEn && LARGE_VARIANT
      && moveWrite.addr >= fps_pkg::RESERVED_BASE
      |=> accessRefused_reg && !cpuStall_reg)
    else $error("reserved region write accepted");

  a_small_unbacked: assert property (
    !LARGE_VARIANT && idle && codeReadReq
      && codeReadAddr >= fps_pkg::SMALL_LIMIT
      |=> codeReadData_reg == fps_pkg::ERASED_BYTE)
    else $error("unbacked read returned data");

  a_write_clears: assert property (
    $fell(cpuStall_reg) && !opErase_reg && !opScratch_reg
      |-> curByte == ($past(curByte) & opData_reg))
    else $error("byte write set a bit");

  a_erase_ones: assert property (
    $fell(cpuStall_reg) && opErase_reg && !opScratch_reg
      |-> curByte == fps_pkg::ERASED_BYTE)
    else $error("erased byte not all ones");

  a_scratch_route: assert property (
    idle && codeReadReq && !codeReadIsFetch && ctl.scratchpadSel
      && codeReadAddr <= fps_pkg::SCRATCH_LAST
      |=> codeReadValid_reg && codeReadData_reg ==
          scratchMem_reg[$past(codeReadAddr[SCR_AW-1:0])])
    else $error("scratchpad read misrouted");

  c_flash_write: cover property (startOp && !ctl.eraseSel);
  c_flash_erase: cover property (startOp && ctl.eraseSel);
  c_scratch_write: cover property (startOp && wrScratch);
  c_refused: cover property (accessRefused_reg);

endmodule : fps_store

// ### core/fps_pkg.sv
// Purpose: shared constants and types for the flash program store access
// Assumes: 100 MHz core clock, 8-bit data, 16-bit program address
// Notes:   timing counts derive from the least write and erase times
package fps_pkg;

  // ----------------------------------------------------------------
  // address space
  // ----------------------------------------------------------------
  localparam int          ADDR_W         = 16;
  localparam int          DATA_W         = 8;
  localparam int          LARGE_BYTES    = 65536;
  localparam int          SMALL_BYTES    = 32768;
  localparam logic [15:0] SMALL_LIMIT    = 16'h8000;
  localparam logic [15:0] RESERVED_BASE  = 16'hfc00;
  localparam int          RESERVED_BYTES = 1024;
  localparam int          SCRATCH_BYTES  = 128;
  localparam logic [15:0] SCRATCH_LAST   = 16'h007f;
  localparam int          SECTOR_BYTES   = 512;
  localparam logic [7:0]  ERASED_BYTE    = 8'hff;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int WRITE_TIME_US = 40;
  localparam int ERASE_TIME_MS = 10;
  localparam int WRITE_CYCLES  =
    (WRITE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_CYCLES  =
    (ERASE_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W       = 20;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WRITE = 2'b01,
    ST_ERASE = 2'b10
  } fps_state_type;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
  } fps_req_type;

  typedef struct packed {
    logic writeRedirectEn;
    logic scratchpadSel;
    logic eraseSel;
  } fps_ctl_type;

endpackage : fps_pkg

// ### core/fps_op_timer.sv
// Purpose: self-timed duration of one flash write or sector erase
// Assumes: start is only raised while not busy
// Notes:   done is high in the last busy cycle
`timescale 1ns/1ps
module fps_op_timer #(
  parameter int WRITE_CYC = fps_pkg::WRITE_CYCLES,
  parameter int ERASE_CYC = fps_pkg::ERASE_CYCLES
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // control
  input  wire logic start,
  input  wire logic isErase,
  // status
  output logic      busy,
  output logic      done
);

  localparam int TW = fps_pkg::TIMER_W;

  logic [TW-1:0] count_reg;
  logic          busy_reg;

  // ----------------------------------------------------------------
  // countdown
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      busy_reg  <= 1'b0;
      count_reg <= '0;
    end else if (start) begin
      busy_reg  <= 1'b1;
      count_reg <= isErase ? TW'(ERASE_CYC - 1) : TW'(WRITE_CYC - 1);
    end else if (busy_reg && count_reg == '0) begin
      busy_reg  <= 1'b0;
    end else if (busy_reg) begin
      count_reg <= count_reg - 1'b1;
    end
  end

  assign busy = busy_reg;
  assign done = busy_reg && (count_reg == '0);

endmodule : fps_op_timer

// ### test/fps_core_model.sv
// Purpose: core model issuing code reads and external move writes
// Assumes: requests launched by nba just after a rising edge
// Notes:   one request at a time; a write waits out its own stall
`timescale 1ns/1ps
module fps_core_model (
  // clock
  input  wire logic                 clk,
  // requests
  output fps_pkg::fps_ctl_type      ctl,
  output logic                      rdReq,
  output logic                      rdFetch,
  output logic [15:0]               rdAddr,
  output logic                      wrReq,
  output fps_pkg::fps_req_type      wr,
  // answers
  input  wire logic                 rdValid,
  input  wire logic [7:0]           rdData,
  input  wire logic                 xramWrite,
  input  wire logic                 stall,
  input  wire logic                 refused
);
  logic intEnable;

  initial begin
    ctl = '0;
    rdReq = 1'b0;
    rdFetch = 1'b0;
    rdAddr = 16'h0000;
    wrReq = 1'b0;
    wr = '0;
    intEnable = 1'b1;
  end

  // ----
  // requests
  // ----
  task automatic setCtl(input logic r, input logic s, input logic e);
    @(posedge clk);
    if (r) intEnable <= 1'b0;
    ctl <= '{writeRedirectEn: r, scratchpadSel: s, eraseSel: e};
    @(posedge clk);
    // interrupts only come back once writes go to ram again
    if (!r) intEnable <= 1'b1;
  endtask : setCtl

  task automatic rd(input logic [15:0] a, input logic f,
                    output logic [7:0] d, output int nv);
    @(posedge clk);
    rdReq <= 1'b1;
    rdAddr <= a;
    rdFetch <= f && !(ctl.scratchpadSel && a <= 16'h007f);
    @(posedge clk);
    rdReq <= 1'b0;
    rdAddr <= ~a;
    #1;
    nv = (rdValid === 1'b1) ? 1 : 0;
    d = rdData;
  endtask : rd

  // stored bytes go out by move write
  task automatic mv(input logic [15:0] a, input logic [7:0] v,
                    output int n, output logic rf, output logic xw,
                    output int nv);
    @(posedge clk);
    wrReq <= 1'b1;
    wr <= '{addr: a, data: v};
    @(posedge clk);
    wrReq <= 1'b0;
    wr <= fps_pkg::fps_req_type'(~{a, v});
    #1;
    rf = refused;
    xw = xramWrite;
    n = 0;
    nv = 0;
    // a stalled core asks for code in its second to fourth stall cycles; none may be answered
    while (stall === 1'b1 && n < 1000) begin
      @(posedge clk);
      rdReq <= (n < 3);
      n++;
      #1;
      if (rdValid !== 1'b0) nv++;
    end
  endtask : mv
endmodule : fps_core_model

// ### test/tb_top.sv
// Purpose: self-checking bench for the flash program store
// Assumes: shortened write and erase counts of 8 and 20 cycles
// Notes:   each sector is erased before use; contents start unknown
`timescale 1ns/1ps
module tb_top;
  logic                 clk;
  logic                 nrst;
  int                   bad_count;
  int                   comparisons;
  int                   cycles;
  fps_pkg::fps_ctl_type ctl;
  logic                 rdReq;
  logic                 rdFetch;
  logic [15:0]          rdAddr;
  logic                 rdValid;
  logic [7:0]           rdData;
  logic [7:0]           smData;
  logic                 wrReq;
  fps_pkg::fps_req_type wr;
  logic                 xramWrite;
  fps_pkg::fps_req_type xramWr;
  logic                 stall;
  logic                 refused;
  logic [7:0]           d;
  logic                 rf;
  logic                 xw;
  int                   n;
  int                   nv;

  fps_store #(.WRITE_CYC(8), .ERASE_CYC(20)) uut (
    .clk(clk), .nrst(nrst), .ctl(ctl),
    .codeReadReq(rdReq), .codeReadIsFetch(rdFetch),
    .codeReadAddr(rdAddr), .codeReadValid_reg(rdValid),
    .codeReadData_reg(rdData), .moveWriteReq(wrReq),
    .moveWrite(wr), .xramWrite_reg(xramWrite), .xramWr_reg(xramWr),
    .cpuStall_reg(stall), .accessRefused_reg(refused));

  // 32 kbyte build on the same stimulus; only its read data is judged
  fps_store #(.LARGE_VARIANT(1'b0), .WRITE_CYC(8), .ERASE_CYC(20)) uutSmall (
    .clk(clk), .nrst(nrst), .ctl(ctl),
    .codeReadReq(rdReq), .codeReadIsFetch(rdFetch),
    .codeReadAddr(rdAddr), .codeReadValid_reg(),
    .codeReadData_reg(smData), .moveWriteReq(wrReq),
    .moveWrite(wr), .xramWrite_reg(), .xramWr_reg(),
    .cpuStall_reg(), .accessRefused_reg());

  fps_core_model core (
    .clk(clk), .ctl(ctl), .rdReq(rdReq), .rdFetch(rdFetch),
    .rdAddr(rdAddr), .wrReq(wrReq), .wr(wr), .rdValid(rdValid),
    .rdData(rdData), .xramWrite(xramWrite), .stall(stall),
    .refused(refused));

  // ----
  // checking
  // ----
  task automatic chk(input string nm, input logic [23:0] s,
                     input logic [23:0] e);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test

  // ----
  // scenarios
  // ----
  task automatic t_main;
    core.setCtl(1'b1, 1'b0, 1'b1);
    core.mv(16'h0205, 8'h00, n, rf, xw, nv);
    chk("erase stall", n, 20);
    chk("stalled reads", nv, 0);
    chk("erase to ram", xw, 1'b0);
    core.setCtl(1'b1, 1'b0, 1'b0);
    core.rd(16'h03ff, 1'b1, d, nv);
    chk("erased byte", d, 8'hff);
    core.mv(16'h0205, 8'h5a, n, rf, xw, nv);
    chk("write stall", n, 8);
    core.rd(16'h0205, 1'b0, d, nv);
    chk("read valid", nv, 1);
    chk("written byte", d, 8'h5a);
    chk("small backed", smData, 8'h5a);
    core.mv(16'h0205, 8'hf0, n, rf, xw, nv);
    core.rd(16'h0205, 1'b0, d, nv);
    chk("rewrite", d, 8'h50);
    core.setCtl(1'b0, 1'b0, 1'b0);
    core.mv(16'h0205, 8'h00, n, rf, xw, nv);
    chk("ram pulse", xw, 1'b1);
    chk("ram pair", xramWr, 24'h020500);
    chk("ram no stall", n, 0);
    core.rd(16'h0205, 1'b0, d, nv);
    chk("flash kept", d, 8'h50);
    $display("test main done");
  endtask : t_main

  task automatic t_scratch;
    core.setCtl(1'b1, 1'b0, 1'b1);
    core.mv(16'h0000, 8'h00, n, rf, xw, nv);
    core.setCtl(1'b1, 1'b0, 1'b0);
    core.mv(16'h007f, 8'h0f, n, rf, xw, nv);
    core.setCtl(1'b1, 1'b1, 1'b1);
    core.mv(16'h0010, 8'h00, n, rf, xw, nv);
    chk("scratch erase", n, 20);
    core.setCtl(1'b1, 1'b1, 1'b0);
    core.mv(16'h007f, 8'h3c, n, rf, xw, nv);
    core.rd(16'h007f, 1'b0, d, nv);
    chk("scratch byte", d, 8'h3c);
    core.rd(16'h0010, 1'b0, d, nv);
    chk("scratch erased", d, 8'hff);
    core.rd(16'h0080, 1'b0, d, nv);
    chk("above scratch", d, 8'hff);
    core.setCtl(1'b1, 1'b0, 1'b0);
    core.rd(16'h007f, 1'b0, d, nv);
    chk("main below", d, 8'h0f);
    $display("test scratch done");
  endtask : t_scratch

  task automatic t_top;
    core.setCtl(1'b1, 1'b0, 1'b1);
    core.mv(16'hfbff, 8'h00, n, rf, xw, nv);
    chk("top erase", n, 20);
    core.mv(16'hffff, 8'h00, n, rf, xw, nv);
    chk("erase refused", rf, 1'b1);
    core.setCtl(1'b1, 1'b0, 1'b0);
    core.mv(16'hfbff, 8'h81, n, rf, xw, nv);
    core.rd(16'hfbff, 1'b1, d, nv);
    chk("top byte", d, 8'h81);
    chk("small unbacked", smData, 8'hff);
    core.mv(16'hfc00, 8'h00, n, rf, xw, nv);
    chk("write refused", rf, 1'b1);
    chk("refused stall", n, 0);
    $display("test top done");
  endtask : t_top

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      stop_test();
    end
  end

  initial begin
    nrst = 1'b0;
    bad_count = 0;
    comparisons = 0;
    cycles = 0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    t_main();
    t_scratch();
    t_top();
    stop_test();
  end
endmodule : tb_top
